/* core/tsc_cmd_parser.sv */
// Purpose: parse version query and tag type select telegrams and answer per channel
// Assumes: bytes arrive as rx_valid pulses; the answer sink is always ready
// Notes: non-volatile store is external; its image is loaded after each reset
`timescale 1ns/1ps
module tsc_cmd_parser
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // head presence per channel
  input wire logic [NUM_CH-1:0] head_present,
  // stored setting image
  input wire logic [NUM_CH*16-1:0] nv_image,
  input wire logic nv_image_valid,
  // answers
  output tsc_pkg::tsc_resp_s resp_q,
  output tsc_pkg::tsc_head_cmd_s head_cmd_q,
  output logic nv_write_q,
  output logic [NUM_CH*16-1:0] nv_data_q,
  output logic [NUM_CH*16-1:0] tag_code_q,
  output logic [NUM_CH*4-1:0] blk_bytes_q,
  output logic [NUM_CH-1:0] iso_uid_any_q,
  output logic [NUM_CH-1:0] head_default_q,
  output logic [NUM_CH*4-1:0] uid_len_max_q
);
  import tsc_pkg::*;

  // ----------------------------------------
  // parser states
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_C0, S_C1, S_CH, S_T0, S_T1, S_HASH, S_CR, S_RESP, S_DISCARD
  } tsc_state_e;

  tsc_state_e state_q, state_d;
  logic is_ver_q, is_ver_d;
  logic all_q, all_d;
  logic [7:0] ch_q, ch_d;
  logic [7:0] c0_q, c0_d;
  logic [7:0] t0_q, t0_d;
  logic [7:0] t1_q, t1_d;
  logic [7:0] err_q, err_d;
  logic [7:0] cur_q, cur_d;
  logic loaded_q;
  logic nv_pend_q;

  function automatic logic [7:0] fold_upper(input logic [7:0] b);
    fold_upper = (b >= 8'h61 && b <= 8'h7A) ? (b & ~CASE_BIT) : b; // see [RL1]
  endfunction

  function automatic logic [7:0] ch_index(input logic [7:0] ch);
    ch_index = ch - CH_ONE;
  endfunction

  function automatic logic is_var_uid(input logic [15:0] code);
    is_var_uid = 1'b0;
    for (int k = 0; k < VAR_UID_COUNT; k++)
      is_var_uid = is_var_uid | (code == VAR_UID_LIST[k]);
  endfunction

  wire [7:0] up = fold_upper(rx_byte);
  wire [15:0] new_code = {t0_q, t1_q};
  wire code_ok;
  tsc_tag_cfg_s new_cfg;

  tsc_tag_decode u_dec (
    .code(new_code),
    .supported(code_ok),
    .cfg(new_cfg)
  );

  wire [7:0] cur_idx = ch_index(cur_q);
  wire ch_in_range = (up >= CH_ONE) && (up < CH_ONE + 8'(NUM_CH));
  wire last_ch = !all_q || (cur_idx == 8'(NUM_CH - 1));
  wire ver_fail = is_ver_q && !head_present[cur_idx[0 +: $clog2(NUM_CH)]];
  // a space inside parameters breaks the grammar and the telegram is dropped
  wire is_space = (rx_byte == 8'h20); // see [RL2]

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    is_ver_d = is_ver_q;
    all_d = all_q;
    ch_d = ch_q;
    c0_d = c0_q;
    t0_d = t0_q;
    t1_d = t1_q;
    err_d = err_q;
    cur_d = cur_q;
    if (rx_valid && state_q != S_RESP)
    begin
      case (state_q)
        S_C0:
          begin
            c0_d = up;
            state_d = (up == CMD_V || up == CMD_C) ? S_C1 : S_DISCARD;
          end
        S_C1:
          begin
            if (c0_q == CMD_V && up == CMD_E)
            begin
              is_ver_d = 1'b1;
              all_d = 1'b1; // see [RL4]
              ch_d = CH_ONE;
              state_d = S_HASH;
            end
            else if (c0_q == CMD_C && up == CMD_T)
            begin
              is_ver_d = 1'b0;
              state_d = S_CH;
            end
            else
              state_d = S_DISCARD;
          end
        S_CH:
          begin
            all_d = (up == fold_upper(CH_ALL)); // see [RL3]
            ch_d = (up == fold_upper(CH_ALL)) ? CH_ONE : up;
            state_d = (up == fold_upper(CH_ALL) || ch_in_range) ? S_T0 : S_DISCARD;
          end
        S_T0:
          begin
            t0_d = rx_byte;
            state_d = is_space ? S_DISCARD : S_T1;
          end
        S_T1:
          begin
            t1_d = rx_byte;
            state_d = is_space ? S_DISCARD : S_HASH;
          end
        S_HASH:
          state_d = (rx_byte == END_HASH) ? S_CR : S_DISCARD;
        S_CR:
          begin
            if (rx_byte == END_CR)
            begin
              err_d = (!is_ver_q && !code_ok) ? ST_ERROR : ST_OK; // see [RL14]
              cur_d = ch_q;
              state_d = S_RESP;
            end
            else
              state_d = S_DISCARD;
          end
        S_DISCARD:
          state_d = (rx_byte == END_CR) ? S_C0 : S_DISCARD;
        default:
          state_d = S_C0;
      endcase
    end
    else if (state_q == S_RESP)
    begin
      cur_d = cur_q + 8'h01; // see [RL15]
      state_d = last_ch ? S_C0 : S_RESP;
    end
  end

  // ----------------------------------------
  // answer and setting update
  // ----------------------------------------
  wire apply = (state_q == S_RESP) && !is_ver_q && (err_q == ST_OK);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      wire hit = apply && (cur_idx == 8'(g));
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
          tag_code_q[g*16 +: 16] <= TT_POWERUP;
        else if (!loaded_q && nv_image_valid)
          tag_code_q[g*16 +: 16] <= nv_image[g*16 +: 16]; // see [RL13]
        else if (hit)
          tag_code_q[g*16 +: 16] <= new_code; // see [RL6]
      end
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
          blk_bytes_q[g*4 +: 4] <= BLK_BYTES_STD;
        else
          blk_bytes_q[g*4 +: 4] <= (tag_code_q[g*16 +: 16] == TT_BLK8) ? BLK_BYTES_WIDE : BLK_BYTES_STD; // see [RL9]
      end
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
        begin
          iso_uid_any_q[g] <= 1'b0;
          head_default_q[g] <= 1'b0;
          uid_len_max_q[g*4 +: 4] <= UID_SHORT;
        end
        else
        begin
          iso_uid_any_q[g] <= (tag_code_q[g*16 +: 16] == TT_ISO_UID); // see [RL8]
          head_default_q[g] <= (tag_code_q[g*16 +: 16] == TT_DEFAULT); // see [RL7]
          // variable types take either length; the actual length comes from the head
          uid_len_max_q[g*4 +: 4] <= is_var_uid(tag_code_q[g*16 +: 16]) ? UID_LONG : UID_SHORT; // see [RL11]
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= S_C0;
      is_ver_q <= 1'b0;
      all_q <= 1'b0;
      ch_q <= CH_ONE;
      c0_q <= 8'h00;
      t0_q <= 8'h00;
      t1_q <= 8'h00;
      err_q <= ST_OK;
      cur_q <= CH_ONE;
      loaded_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      is_ver_q <= is_ver_d;
      all_q <= all_d;
      ch_q <= ch_d;
      c0_q <= c0_d;
      t0_q <= t0_d;
      t1_q <= t1_d;
      err_q <= err_d;
      cur_q <= cur_d;
      loaded_q <= loaded_q | nv_image_valid;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      resp_q <= '0;
      head_cmd_q <= '0;
      nv_pend_q <= 1'b0;
      nv_write_q <= 1'b0;
      nv_data_q <= '0;
    end
    else
    begin
      resp_q.valid <= (state_q == S_RESP);
      resp_q.status <= ver_fail ? ST_NO_HEAD : err_q; // see [RL5] see [RL12]
      resp_q.channel <= cur_q;
      resp_q.version <= is_ver_q && !ver_fail; // see [RL4]
      head_cmd_q.valid <= apply; // see [RL6]
      head_cmd_q.channel <= cur_q;
      head_cmd_q.code <= new_code;
      // write a cycle late so the image already holds the last channel's new code
      nv_pend_q <= (state_q == S_RESP) && last_ch && !is_ver_q && (err_q == ST_OK); // see [RL6]
      nv_write_q <= nv_pend_q;
      nv_data_q <= tag_code_q;
    end
  end
endmodule

/* core/tsc_pkg.sv */
// Purpose: constants and carriers for the system command parser of a two-channel tag reader control unit
// Assumes: ascii telegrams arrive one byte per cycle from a uart receiver on core_clk
// Notes: the check sum and baud handling sit outside this block
// Operation
// [RL1] command letters match regardless of upper or lower case
// [RL2] host sends parameters after the command without any space characters
// [RL3] channel selector x applies the command to every channel
// [RL4] version query answers unit and head names, numbers, dates, one per channel
// [RL5] channel without head answers status 6 and channel number only; the parser checks head_present for the version query only
// [RL6] tag type select informs the head and keeps setting in non-volatile store
// [RL7] code 99 uses the default tag type held in the head
// [RL8] code 20 reads the identifier of any iso 15693 tag
// [RL9] code 33 addresses tag memory in 8-byte blocks, not 4-byte
// [RL10] host gives even block count of at most 7 for code 33
// [RL11] variable-length identifier types accept 4-byte or 7-byte identifiers
// [RL12] status 0 means accepted, status 5 means no tag in range
// [RL13] stored settings become active after every reset
// [RL14] unsupported tag type code is refused with error, setting unchanged
// [RL15] all-channel answers come as separate telegrams in ascending channel order
package tsc_pkg;
  localparam int NUM_CH = 2;
  localparam logic [7:0] CH_ALL = 8'h78;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CMD_V = 8'h56;
  localparam logic [7:0] CMD_E = 8'h45;
  localparam logic [7:0] CMD_C = 8'h43;
  localparam logic [7:0] CMD_T = 8'h54;
  localparam logic [7:0] END_HASH = 8'h23;
  localparam logic [7:0] END_CR = 8'h0D;
  localparam logic [7:0] ST_OK = 8'h30;
  localparam logic [7:0] ST_NO_TAG = 8'h35;
  localparam logic [7:0] ST_NO_HEAD = 8'h36;
  localparam logic [7:0] ST_ERROR = 8'h34;
  localparam logic [15:0] TT_DEFAULT = 16'h3939;
  localparam logic [15:0] TT_ISO_UID = 16'h3230;
  localparam logic [15:0] TT_BLK8 = 16'h3333;
  localparam logic [15:0] TT_POWERUP = 16'h3939;
  localparam int TT_COUNT = 25;
  localparam logic [15:0] TT_LIST [TT_COUNT] = '{
    16'h3032, 16'h3033, 16'h3131, 16'h3132, 16'h3230, 16'h3231, 16'h3232,
    16'h3233, 16'h3234, 16'h3331, 16'h3333, 16'h3334, 16'h3335, 16'h3430,
    16'h3431, 16'h3432, 16'h3433, 16'h3530, 16'h3532, 16'h3732, 16'h3733,
    16'h3734, 16'h3735, 16'h3736, 16'h3939};
  localparam int VAR_UID_COUNT = 3;
  localparam logic [15:0] VAR_UID_LIST [VAR_UID_COUNT] = '{16'h3430, 16'h3432, 16'h3433};
  localparam logic [3:0] BLK_BYTES_STD = 4'h4;
  localparam logic [3:0] BLK_BYTES_WIDE = 4'h8;
  localparam logic [3:0] UID_SHORT = 4'h4;
  localparam logic [3:0] UID_LONG = 4'h7;

  typedef struct packed {
    logic [15:0] code;
    logic [3:0] blk_bytes;
    logic iso_uid_any;
    logic head_default;
    logic var_uid;
  } tsc_tag_cfg_s;

  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [7:0] channel;
    logic version;
  } tsc_resp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] channel;
    logic [15:0] code;
  } tsc_head_cmd_s;
endpackage

/* core/tsc_tag_decode.sv */
// Purpose: classify a two-character tag type code
// Assumes: code is two ascii digits, high char in upper byte
// Notes: purely combinational
`timescale 1ns/1ps
module tsc_tag_decode
  import tsc_pkg::*;
(
  // code in
  input wire logic [15:0] code,
  // classification
  output logic supported,
  output tsc_pkg::tsc_tag_cfg_s cfg
);
  logic [TT_COUNT-1:0] hit;
  logic [VAR_UID_COUNT-1:0] vhit;

  genvar i;
  generate
    for (i = 0; i < TT_COUNT; i++)
    begin : g_tt
      assign hit[i] = (code == TT_LIST[i]);
    end
    for (i = 0; i < VAR_UID_COUNT; i++)
    begin : g_vu
      assign vhit[i] = (code == VAR_UID_LIST[i]);
    end
  endgenerate

  assign supported = |hit; // see [RL14]
  assign cfg.code = code;
  assign cfg.blk_bytes = (code == TT_BLK8) ? BLK_BYTES_WIDE : BLK_BYTES_STD; // see [RL9]
  assign cfg.iso_uid_any = (code == TT_ISO_UID); // see [RL8]
  assign cfg.head_default = (code == TT_DEFAULT); // see [RL7]
  assign cfg.var_uid = |vhit; // see [RL11]
endmodule

/* bench/tsc_assertions.sv */
// Purpose: port checks for the command parser
// Assumes: head_present steady while answers go out
// Notes: config checks wait until a code has settled for a cycle
`timescale 1ns/1ps
module tsc_assertions
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // watched ports
  input wire logic [NUM_CH-1:0] head_present,
  input wire tsc_pkg::tsc_resp_s resp_q,
  input wire tsc_pkg::tsc_head_cmd_s head_cmd_q,
  input wire logic nv_write_q,
  input wire logic [NUM_CH*16-1:0] tag_code_q,
  input wire logic [NUM_CH*4-1:0] blk_bytes_q,
  input wire logic [NUM_CH-1:0] iso_uid_any_q,
  input wire logic [NUM_CH-1:0] head_default_q,
  input wire logic [NUM_CH*4-1:0] uid_len_max_q
);
  logic [NUM_CH*16-1:0] prev_q;
  logic live_q;
  logic set1;
  logic set2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // settle markers tolerate a one-cycle lag of the decoded outputs
  always_ff @(posedge core_clk)
  begin
    prev_q <= tag_code_q;
    live_q <= rstn;
  end
  assign set1 = live_q && tag_code_q[15:0] == prev_q[15:0];
  assign set2 = live_q && tag_code_q[31:16] == prev_q[31:16];
  // ----------------
  // checks
  // ----------------
  property p_head_ok;
    head_cmd_q.valid |-> resp_q.valid && resp_q.status == ST_OK && head_cmd_q.channel == resp_q.channel;
  endproperty
  a_head_ok: assert property (p_head_ok) else $error("head notice without ok answer");
  property p_nv;
    nv_write_q |-> head_cmd_q.valid || $past(head_cmd_q.valid);
  endproperty
  a_nv: assert property (p_nv) else $error("store write without head notice");
  property p_blk8;
    set1 && tag_code_q[15:0] == TT_BLK8 |-> blk_bytes_q[3:0] == BLK_BYTES_WIDE;
  endproperty
  a_blk8: assert property (p_blk8) else $error("wide block size missing");
  property p_iso;
    set2 && tag_code_q[31:16] == TT_ISO_UID |-> iso_uid_any_q[1];
  endproperty
  a_iso: assert property (p_iso) else $error("any-tag uid mode missing");
  property p_dflt;
    set1 && tag_code_q[15:0] == TT_DEFAULT |-> head_default_q[0];
  endproperty
  a_dflt: assert property (p_dflt) else $error("head default mode missing");
  property p_uid;
    set1 && tag_code_q[15:0] inside {VAR_UID_LIST} |-> uid_len_max_q[3:0] == UID_LONG;
  endproperty
  a_uid: assert property (p_uid) else $error("long uid not allowed");
  property p_asc;
    resp_q.valid && $past(resp_q.valid) |-> resp_q.channel == $past(resp_q.channel) + 8'h01;
  endproperty
  a_asc: assert property (p_asc) else $error("answers out of channel order");
  // head presence is taken one cycle before the answer leaves
  property p_no_head;
    resp_q.valid && (resp_q.version || resp_q.status == ST_NO_HEAD) |->
      resp_q.version == (resp_q.channel == 8'h32 ? $past(head_present[1]) : $past(head_present[0])) &&
      resp_q.status == (resp_q.version ? ST_OK : ST_NO_HEAD);
  endproperty
  a_no_head: assert property (p_no_head) else $error("version status wrong");
  property p_err;
    resp_q.valid && resp_q.status == ST_ERROR |-> !head_cmd_q.valid && !nv_write_q;
  endproperty
  a_err: assert property (p_err) else $error("refused code still stored");
endmodule

/* bench/tsc_host_model.sv */
// Purpose: host side sending ascii telegrams
// Assumes: caller waits for the answers before the next telegram
// Notes: carriage return appended to every telegram
`timescale 1ns/1ps
module tsc_host_model
  import tsc_pkg::*;
(
  // clock
  input wire logic core_clk,
  // byte stream
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
  end
  task automatic send(input string tel);
    for (int i = 0; i <= tel.len(); i++)
    begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      // only system telegrams go out, so no block count is ever sent
      rx_byte <= (i < tel.len()) ? tel[i] : END_CR;
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    // released line shows the inverse, never a stale byte
    rx_byte <= ~rx_byte;
  endtask
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the command parser
// Assumes: one byte per cycle from the host model
// Notes: a telegram with a space must stay unanswered
`timescale 1ns/1ps
module tb;
  import tsc_pkg::*;
  logic core_clk;
  logic rstn;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [NUM_CH-1:0] head_present;
  logic [NUM_CH*16-1:0] nv_image;
  logic nv_image_valid;
  tsc_resp_s resp_q;
  tsc_head_cmd_s head_cmd_q;
  logic nv_write_q;
  logic [NUM_CH*16-1:0] nv_data_q;
  logic [NUM_CH*16-1:0] tag_code_q;
  logic [NUM_CH*4-1:0] blk_bytes_q;
  logic [NUM_CH*4-1:0] uid_len_max_q;
  logic [NUM_CH-1:0] iso_uid_any_q;
  logic [NUM_CH-1:0] head_default_q;
  int bad_count;
  int total_checks;
  int cyc;
  int resp_cnt;
  tsc_host_model tsc_host_model_inst (.core_clk, .rx_valid, .rx_byte);
  tsc_cmd_parser tsc_cmd_parser_inst (.core_clk, .rstn, .rx_valid, .rx_byte, .head_present, .nv_image,
    .nv_image_valid, .resp_q, .head_cmd_q, .nv_write_q, .nv_data_q, .tag_code_q, .blk_bytes_q,
    .iso_uid_any_q, .head_default_q, .uid_len_max_q);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wait_resp;
    int n;
    n = 0;
    do
    begin
      settle(1);
      n++;
    end while (resp_q.valid !== 1'b1 && n < 40);
    chk("answer", resp_q.valid, 1'b1);
  endtask
  task ct_one(input string tel, input logic [7:0] ch, input logic [7:0] st, input logic [31:0] tags);
    tsc_host_model_inst.send(tel);
    wait_resp;
    chk("status", resp_q.status, st);
    chk("channel", resp_q.channel, ch);
    chk("head notice", head_cmd_q.valid, st == ST_OK);
    if (st == ST_OK)
      chk("head code", {head_cmd_q.channel, head_cmd_q.code},
        {ch, (ch == CH_ONE) ? tags[15:0] : tags[31:16]});
    settle(1);
    chk("store write", nv_write_q, st == ST_OK);
    chk("store data", nv_data_q, tags);
    settle(2);
    chk("stored codes", tag_code_q, tags);
  endtask
  task ct_all(input string tel, input logic [15:0] code);
    tsc_host_model_inst.send(tel);
    wait_resp;
    chk("first channel", resp_q.channel, 8'h31);
    chk("early store write", nv_write_q, 1'b0);
    settle(1);
    chk("second answer", {resp_q.valid, resp_q.channel}, {1'b1, 8'h32});
    settle(1);
    chk("store write", nv_write_q, 1'b1);
    chk("store data", nv_data_q, {code, code});
    settle(2);
    chk("both codes", tag_code_q, {code, code});
  endtask
  task t_refuse;
    int seen0;
    seen0 = resp_cnt;
    tsc_host_model_inst.send("CT1 03#");
    settle(4);
    chk("spaced telegram answers", resp_cnt - seen0, 0);
    chk("spaced telegram codes", tag_code_q, {TT_BLK8, 16'h3033});
  endtask
  task t_version;
    head_present <= 2'b01;
    tsc_host_model_inst.send("ve#");
    wait_resp;
    chk("unit answer", {resp_q.version, resp_q.status, resp_q.channel}, {1'b1, ST_OK, 8'h31});
    settle(1);
    chk("absent head", {resp_q.version, resp_q.status, resp_q.channel}, {1'b0, ST_NO_HEAD, 8'h32});
  endtask
  task t_rerun;
    nv_image <= {16'h3033, TT_ISO_UID};
    rstn <= 1'b0;
    settle(2);
    chk("held codes", tag_code_q, {TT_POWERUP, TT_POWERUP});
    chk("held answer", resp_q.valid, 1'b0);
    rstn <= 1'b1;
    settle(3);
    chk("reloaded codes", tag_code_q, {16'h3033, TT_ISO_UID});
    chk("reloaded any uid", iso_uid_any_q, 2'b01);
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (resp_q.valid === 1'b1)
      resp_cnt++;
    if (cyc > 3000)
    begin
      bad_count++;
      end_sim;
    end
  end
  initial
  begin
    rstn = 1'b0;
    head_present = 2'b11;
    nv_image = {TT_ISO_UID, TT_BLK8};
    nv_image_valid = 1'b0;
    settle(2);
    rstn <= 1'b1;
    settle(1);
    chk("reset codes", tag_code_q, {TT_POWERUP, TT_POWERUP});
    chk("reset blocks", blk_bytes_q, {BLK_BYTES_STD, BLK_BYTES_STD});
    chk("reset uid", uid_len_max_q, {UID_SHORT, UID_SHORT});
    nv_image_valid <= 1'b1;
    settle(5);
    chk("loaded codes", tag_code_q, {TT_ISO_UID, TT_BLK8});
    chk("wide blocks", blk_bytes_q[3:0], BLK_BYTES_WIDE);
    chk("any uid", iso_uid_any_q, 2'b10);
    ct_one("CT103#", 8'h31, ST_OK, {TT_ISO_UID, 16'h3033});
    ct_one("ct233#", 8'h32, ST_OK, {TT_BLK8, 16'h3033});
    ct_one("CT115#", 8'h31, ST_ERROR, {TT_BLK8, 16'h3033});
    t_refuse;
    ct_all("CTx42#", 16'h3432);
    chk("long uid", uid_len_max_q, {UID_LONG, UID_LONG});
    ct_all("cTX99#", TT_DEFAULT);
    chk("head default", head_default_q, 2'b11);
    t_version;
    t_rerun;
    end_sim;
  end
endmodule
bind tsc_cmd_parser tsc_assertions tsc_assertions_inst (.core_clk, .rstn, .head_present, .resp_q, .head_cmd_q,
  .nv_write_q, .tag_code_q, .blk_bytes_q, .iso_uid_any_q, .head_default_q, .uid_len_max_q);
